//--- hw/sft_pkg.sv
// Package: constants and types for the serial FIFO threshold controller
package sft_pkg;
  localparam int FIFO_DEPTH = 2;
  localparam int CNT_W = 2;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h3;
  localparam logic [3:0] OFS_IRQ_EN = 4'h4;
  // Control field positions
  localparam int CTRL_TX_LEVEL_THRESHOLD_LSB = 4;
  localparam int CTRL_RQE_BIT = 3;
  localparam int CTRL_FLUSH_BIT = 2;
  localparam int CTRL_RX_LEVEL_THRESHOLD_LSB = 0;
  // Status field positions
  localparam int STAT_TXREQ_BIT = 7;
  localparam int STAT_RXREQ_BIT = 3;
  // Event bits
  localparam int EV_TXREQ = 0;
  localparam int EV_RXREQ = 1;
  // Reset values
  localparam logic [1:0] TX_LEVEL_THRESHOLD_RST = 2'h0;
  localparam logic [1:0] RX_LEVEL_THRESHOLD_RST = 2'h0;
  localparam logic RQE_RST = 1'b0;
  localparam logic [1:0] EV_RST = 2'h0;
  // Transmit threshold codes and the zero read-data value
  localparam logic [1:0] TX_LEVEL_THRESHOLD_EMPTY = 2'h0;
  localparam logic [1:0] TX_LEVEL_THRESHOLD_ONE = 2'h1;
  localparam logic [7:0] RD_ZERO = 8'h00;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } sft_bus_req_t;

  typedef struct packed {
    logic push;
    logic pop;
  } sft_fifo_op_t;
endpackage

//--- hw/sft_ctrl.sv
// Threshold, request, interrupt and flush control for the serial port FIFOs
// Function
// RQ1: Transmit threshold code 0 requests on empty, code 1 on one byte or fewer.
// RQ2: With read-request enable set, interrupt stays high while receive request is set.
// RQ3: Read-request enable is read-write, resets 0; when 0 it gives no interrupt.
// RQ4: Writing receive flush clears receive counters, drops bytes; hardware clears the bit.
// RQ5: Receive request asserts while receive count exceeds receive threshold, reset zero.
// RQ6: Transmit request is 1 while transmit count is at or below threshold.
//
// The strobed register port and the address map were left to the implementer.
module sft_ctrl (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Register port
  input wire sft_pkg::sft_bus_req_t bus_req,
  output logic [sft_pkg::DATA_W-1:0] rd_data,
  // Shift engine side
  input wire sft_pkg::sft_fifo_op_t tx_op,
  input wire sft_pkg::sft_fifo_op_t rx_op,
  output logic [sft_pkg::CNT_W:0] tx_count,
  output logic [sft_pkg::CNT_W:0] rx_count,
  output logic tx_space_request,
  output logic rx_data_request,
  output logic rx_flush_busy,
  // Interrupt
  output logic serial_port_zero_irq
);
  import sft_pkg::*;

  // Control fields
  logic [1:0] tx_level_threshold_q;
  logic [1:0] rx_level_threshold_q;
  logic rx_request_irq_enable_q;
  logic rx_flush_q;
  // FIFO counts and limit
  logic [CNT_W:0] tx_cnt_q;
  logic [CNT_W:0] rx_cnt_q;
  logic [CNT_W:0] tx_limit;
  // Interrupt state
  logic [1:0] ev_q;
  logic [1:0] ev_d;
  logic [1:0] ev_en_q;
  logic [1:0] ev_now;
  logic [1:0] ev_gate;
  logic irq_rx_level;
  logic irq_event;
  // Bus decodes and read path
  logic wr_ctrl;
  logic wr_irq_clr;
  logic wr_irq_en;
  logic flush_req;
  logic [DATA_W-1:0] rd_data_d;

  //////////////////////////////////////////////////////////////////////////
  // Register write decode
  assign wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);
  assign wr_irq_clr = bus_req.wr && (bus_req.addr == OFS_IRQ_CLR);
  assign wr_irq_en = bus_req.wr && (bus_req.addr == OFS_IRQ_EN);
  assign flush_req = wr_ctrl && bus_req.wdata[CTRL_FLUSH_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tx_level_threshold_q <= TX_LEVEL_THRESHOLD_RST; // [RQ1]
      rx_level_threshold_q <= RX_LEVEL_THRESHOLD_RST; // [RQ5]
      rx_request_irq_enable_q <= RQE_RST; // [RQ3]
    end
    else if (wr_ctrl)
    begin
      tx_level_threshold_q <= bus_req.wdata[CTRL_TX_LEVEL_THRESHOLD_LSB +: 2]; // [RQ1]
      rx_level_threshold_q <= bus_req.wdata[CTRL_RX_LEVEL_THRESHOLD_LSB +: 2]; // [RQ5]
      rx_request_irq_enable_q <= bus_req.wdata[CTRL_RQE_BIT]; // [RQ3]
    end
  end

  // Flush runs for one cycle after the write, then hardware clears the bit
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rx_flush_q <= 1'h0;
    end
    else if (flush_req)
    begin
      rx_flush_q <= 1'h1; // [RQ4]
    end
    else
    begin
      rx_flush_q <= 1'h0; // [RQ4]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // FIFO occupancy counters; push and pop together leave the count alone
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      tx_cnt_q <= '0;
    end
    else if (tx_op.push && !tx_op.pop && tx_cnt_q != (CNT_W+1)'(FIFO_DEPTH))
    begin
      tx_cnt_q <= tx_cnt_q + 1'h1;
    end
    else if (tx_op.pop && !tx_op.push && tx_cnt_q != '0)
    begin
      tx_cnt_q <= tx_cnt_q - 1'h1;
    end
  end

  // A flush drops every stored byte, and a push in the flush cycle too
  always_ff @(posedge sys_clk)
  begin
    if (srst || rx_flush_q)
    begin
      rx_cnt_q <= '0; // [RQ4]
    end
    else if (rx_op.push && !rx_op.pop && rx_cnt_q != (CNT_W+1)'(FIFO_DEPTH))
    begin
      rx_cnt_q <= rx_cnt_q + 1'h1;
    end
    else if (rx_op.pop && !rx_op.push && rx_cnt_q != '0)
    begin
      rx_cnt_q <= rx_cnt_q - 1'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request flags
  always_comb
  begin
    unique case (tx_level_threshold_q)
      TX_LEVEL_THRESHOLD_EMPTY: tx_limit = '0; // [RQ1]
      TX_LEVEL_THRESHOLD_ONE: tx_limit = (CNT_W+1)'(1); // [RQ1]
      default: tx_limit = '0;
    endcase
  end

  assign tx_space_request = (tx_cnt_q <= tx_limit); // [RQ6]
  assign rx_data_request = (rx_cnt_q > {1'h0, rx_level_threshold_q}); // [RQ5]
  assign tx_count = tx_cnt_q;
  assign rx_count = rx_cnt_q;
  assign rx_flush_busy = rx_flush_q;

  //////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear
  assign ev_now[EV_TXREQ] = tx_space_request;
  assign ev_now[EV_RXREQ] = rx_data_request;

  always_comb
  begin
    ev_d = ev_q | ev_now;
    if (wr_irq_clr)
    begin
      ev_d = (ev_q & ~bus_req.wdata[1:0]) | ev_now;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ev_q <= EV_RST;
    end
    else
    begin
      ev_q <= ev_d;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ev_en_q <= EV_RST;
    end
    else if (wr_irq_en)
    begin
      ev_en_q <= bus_req.wdata[1:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Interrupt output
  // Receive event reaches the line only while the read-request enable is set
  assign ev_gate[EV_TXREQ] = 1'h1;
  assign ev_gate[EV_RXREQ] = rx_request_irq_enable_q; // [RQ3]
  assign irq_rx_level = rx_request_irq_enable_q && rx_data_request; // [RQ2] [RQ3]
  assign irq_event = |(ev_q & ev_en_q & ev_gate);
  assign serial_port_zero_irq = irq_rx_level || irq_event;

  //////////////////////////////////////////////////////////////////////////
  // Read data, valid the cycle after the strobe and zero otherwise
  always_comb
  begin
    rd_data_d = RD_ZERO;
    if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFS_CTRL: rd_data_d = {2'h0, tx_level_threshold_q, rx_request_irq_enable_q,
                               rx_flush_q, rx_level_threshold_q};
        OFS_STATUS: rd_data_d = {tx_space_request, 3'h0, rx_data_request, 3'h0};
        OFS_IRQ_STAT: rd_data_d = {6'h00, ev_q};
        OFS_IRQ_EN: rd_data_d = {6'h00, ev_en_q};
        default: rd_data_d = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rd_data <= RD_ZERO;
    end
    else
    begin
      rd_data <= rd_data_d;
    end
  end
endmodule // sft_ctrl

//--- test/sft_ctrl_sva.sv
// Checker for the serial FIFO threshold controller
module sft_ctrl_sva (
  // Watched ports
  input wire logic sys_clk,
  input wire logic srst,
  input wire sft_pkg::sft_bus_req_t bus_req,
  input wire logic [sft_pkg::CNT_W:0] tx_count,
  input wire logic [sft_pkg::CNT_W:0] rx_count,
  input wire logic tx_space_request,
  input wire logic rx_data_request,
  input wire logic rx_flush_busy,
  input wire logic serial_port_zero_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import sft_pkg::*;
  logic [7:0] ctl_q;
  logic [1:0] en_q;
  logic flush_wr;
  assign flush_wr = bus_req.wr && bus_req.addr == OFS_CTRL && bus_req.wdata[CTRL_FLUSH_BIT];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Shadow of control and enable writes
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctl_q <= 8'h00;
      en_q <= 2'h0;
    end
    else if (bus_req.wr && bus_req.addr == OFS_CTRL)
      ctl_q <= bus_req.wdata;
    else if (bus_req.wr && bus_req.addr == OFS_IRQ_EN)
      en_q <= bus_req.wdata[1:0];
  end
  AST_TX_EMPTY: assert property (ctl_q[5:4] == TX_LEVEL_THRESHOLD_EMPTY && tx_count == 1 |->
    !tx_space_request) else $error("tx request with one byte at code zero");
  AST_TX_REQ: assert property (tx_space_request == (tx_count <= (ctl_q[5:4] == TX_LEVEL_THRESHOLD_ONE)))
    else $error("tx request disagrees with count");
  AST_RX_REQ: assert property (rx_data_request == (rx_count > ctl_q[1:0]))
    else $error("rx request disagrees with count");
  AST_IRQ_ON: assert property (ctl_q[3] && rx_data_request |-> serial_port_zero_irq)
    else $error("irq missing");
  AST_IRQ_OFF: assert property (!ctl_q[3] && en_q == 0 |-> !serial_port_zero_irq)
    else $error("irq while disabled");
  AST_FLUSH: assert property (bus_req.wr && bus_req.addr == OFS_CTRL && bus_req.wdata[2]
    |-> ##[1:2] rx_count == 0) else $error("flush left bytes");
  AST_FLUSH_BUSY: assert property (flush_wr |=> rx_flush_busy)
    else $error("flush bit not set after write");
  AST_FLUSH_DONE: assert property (rx_flush_busy && !flush_wr |=> !rx_flush_busy)
    else $error("flush bit not returned to zero");
  AST_IRQ_RX_MASK: assert property (!ctl_q[CTRL_RQE_BIT] && !en_q[EV_TXREQ] |->
    !serial_port_zero_irq) else $error("rx request raised irq while disabled");
  cover property (serial_port_zero_irq);
  cover property (tx_count == 2);
  cover property (bus_req.wr && bus_req.wdata[2]);
endmodule // sft_ctrl_sva
bind sft_ctrl sft_ctrl_sva chk_i (.sys_clk, .srst, .bus_req, .tx_count, .rx_count,
  .tx_space_request, .rx_data_request, .rx_flush_busy, .serial_port_zero_irq);

//--- test/sft_eng_model.sv
// Shift engine model: one-cycle push and pop strobes
module sft_eng_model (
  // Clock and strobes
  input wire logic sys_clk,
  output sft_pkg::sft_fifo_op_t tx_op,
  output sft_pkg::sft_fifo_op_t rx_op
);
  timeunit 1ns;
  timeprecision 1ns;
  import sft_pkg::*;
  initial {tx_op, rx_op} = 4'h0;
  task automatic op(input logic [3:0] v);
    @(posedge sys_clk) {tx_op, rx_op} <= v;
    @(posedge sys_clk) {tx_op, rx_op} <= 4'h0;
  endtask
endmodule // sft_eng_model

//--- test/test_sft_ctrl.sv
// Testbench for the serial FIFO threshold controller
module test_sft_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import sft_pkg::*;
  logic sys_clk = 0;
  logic srst = 1;
  sft_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  sft_fifo_op_t tx_op, rx_op;
  logic [CNT_W:0] tx_count, rx_count;
  logic txr, rxr, irq, fb;
  int err_count = 0;
  int n_checks = 0;
  always #5 sys_clk = ~sys_clk;
  sft_eng_model eng (.sys_clk, .tx_op, .rx_op);
  sft_ctrl uut (.sys_clk, .srst, .bus_req, .rd_data, .tx_op, .rx_op, .tx_count, .rx_count,
    .tx_space_request(txr), .rx_data_request(rxr), .rx_flush_busy(fb), .serial_port_zero_irq(irq));
  task automatic chk(input string n, input logic [7:0] s, e);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus_req.wr <= 0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk) bus_req.rd <= 0;
    #1 chk("rd_data", rd_data, e);
  endtask
  task automatic summarize;
    if (err_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 0;
    rd(OFS_CTRL, 8'h00);
    rd(OFS_STATUS, 8'h80);
    chk("tx_space_request", txr, 1);
    eng.op(4'b1000);
    rd(OFS_STATUS, 8'h00);
    wr(OFS_IRQ_CLR, 8'h03);
    wr(OFS_IRQ_EN, 8'h01);
    rd(OFS_IRQ_STAT, 8'h00);
    wr(OFS_CTRL, 8'h10);
    rd(OFS_STATUS, 8'h80);
    chk("irq", irq, 1);
    wr(OFS_IRQ_EN, 8'h00);
    chk("irq", irq, 0);
    eng.op(4'b1000);
    rd(OFS_STATUS, 8'h00);
    chk("tx_count", tx_count, 2);
    eng.op(4'b0010);
    rd(OFS_STATUS, 8'h08);
    chk("rx_data_request", rxr, 1);
    chk("irq", irq, 0);
    wr(OFS_IRQ_EN, 8'h02);
    chk("irq", irq, 0);
    wr(OFS_IRQ_EN, 8'h00);
    wr(OFS_CTRL, 8'h08);
    chk("irq", irq, 1);
    wr(OFS_CTRL, 8'h09);
    chk("irq", irq, 0);
    wr(OFS_CTRL, 8'h0C);
    chk("rx_flush_busy", fb, 1);
    repeat (2) @(posedge sys_clk);
    rd(OFS_CTRL, 8'h08);
    chk("rx_count", rx_count, 0);
    chk("rx_flush_busy", fb, 0);
    wr(OFS_CTRL, 8'h20);
    rd(OFS_STATUS, 8'h00);
    rd(4'hF, 8'h00);
    summarize;
  end
endmodule // test_sft_ctrl
